// ### core/scw_cfg.svh
`ifndef SCW_CFG_SVH
`define SCW_CFG_SVH
// Contract
// (RULE_01) Forced-continuous select at 1 keeps continuous conduction; at 0 discontinuous mode follows low-side zero crossing.
// (RULE_02) Writes to forced-continuous select are always stored but reach the converter only while the rail is disabled; when stacked the code stores 1.
// (RULE_03) In a stacked configuration forced-continuous select is held at 1 whatever is written.
// (RULE_04) Bits 14:13 and 6:5 reset to 00b and always read as zero.
// (RULE_05) Soft-start discontinuous enable at 1 permits discontinuous mode during soft start over the forced setting; at 0 it is off then.
// In a stacked configuration the code keeps discontinuous mode off during soft start, whatever this bit holds.
// (RULE_06) Power-good delay field sets the time from soft-start-done high to power-good high: 0.0015ms, 0.5ms, 1ms, 2ms.
// (RULE_07) The power-good delay is applied once per start-up of the rail only.
// (RULE_08) Writes to the power-good delay field are stored at once but take effect only after the rail is disabled.
// (RULE_09) Undercurrent threshold select chooses the threshold that protection compares against.
// (RULE_10) Checksum-required flag is ignored when the device is not the stack primary.
// (RULE_11) With checksum-required flag at 0, commands without checksum are accepted and an appended checksum is verified.
// (RULE_12) With checksum-required flag at 1, a transaction without checksum is rejected as if its checksum were invalid.
// (RULE_13) The register is reached by word write and word read transactions answered with a two-byte unsigned value.
// (RULE_14) External-divider status ignores writes and reads back the strapped value.
// (RULE_15) Fixed overvoltage disable bit at 0 enables the fixed overvoltage fault and at 1 disables it.
// (RULE_16) At power-up the nonvolatile word is loaded before the rail is enabled or transactions are served.

`define SCW_CMD_CODE 8'hd1
`define SCW_B_FORCED_CONTINUOUS_SEL 15
`define SCW_B_SSDCM 12
`define SCW_F_PGD_HI 11
`define SCW_F_PGD_LO 10
`define SCW_F_UTH_HI 9
`define SCW_F_UTH_LO 8
`define SCW_F_RSVA_HI 14
`define SCW_F_RSVA_LO 13
`define SCW_F_RSVB_HI 6
`define SCW_F_RSVB_LO 5
`define SCW_B_PEC 7
`define SCW_B_EXTDIV 4
`define SCW_B_HIRST 3
`define SCW_B_RSTEN 2
`define SCW_B_OVLVL 1
`define SCW_B_OVDIS 0
`define SCW_STORE_MASK 16'h9f8f
`define SCW_RESET_WORD 16'h0000
`define SCW_PGD_SEL_0 2'h0
`define SCW_PGD_SEL_1 2'h1
`define SCW_PGD_SEL_2 2'h2
`define SCW_CLK_PERIOD_NS 10
`define SCW_PGD_T0_NS 1500
`define SCW_PGD_T1_NS 500000
`define SCW_PGD_T2_NS 1000000
`define SCW_PGD_T3_NS 2000000
`define SCW_NS_TO_CYC(t) (((t) + `SCW_CLK_PERIOD_NS - 1) / `SCW_CLK_PERIOD_NS)
`define SCW_PGD_CW 18
`endif

// ### core/scw_pec_gate.sv
`timescale 1ns/1ns
module scw_pec_gate (
  input wire logic checksum_required_i,
  input wire logic primary_i,
  input wire logic pec_present_i,
  input wire logic pec_ok_i,
  output logic accept_o
);
  always_comb begin
    if (pec_present_i) begin
      accept_o = pec_ok_i; // RULE_11
    end else begin
      accept_o = !(checksum_required_i && primary_i); // RULE_10 RULE_12
    end
  end
endmodule

// ### core/scw_pg_delay.sv
`timescale 1ns/1ns
`include "scw_cfg.svh"
module scw_pg_delay #(
  parameter int CW = `SCW_PGD_CW
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic rail_en_i,
  input wire logic ss_done_i,
  input wire logic [CW-1:0] delay_cycles_i,
  output logic pg_o
);
  import scw_pkg::*;

  scw_pg_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic pg_r, pg_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      SCW_PG_IDLE: begin
        cnt_nxt = '0;
        if (rail_en_i && ss_done_i) begin
          state_nxt = SCW_PG_COUNT;
        end
      end
      SCW_PG_COUNT: begin
        // A drop of soft-start-done restarts the deglitch window
        if (!rail_en_i || !ss_done_i) begin
          state_nxt = SCW_PG_IDLE;
        end else if (CW'(cnt_r + 1'b1) >= delay_cycles_i) begin
          state_nxt = SCW_PG_DONE; // RULE_06
        end else begin
          cnt_nxt = CW'(cnt_r + 1'b1);
        end
      end
      SCW_PG_DONE: begin
        // Later transitions pass straight through until the rail restarts
        if (!rail_en_i) begin
          state_nxt = SCW_PG_IDLE; // RULE_07
        end
      end
      default: state_nxt = SCW_PG_IDLE;
    endcase
    pg_nxt = (state_r == SCW_PG_DONE) && rail_en_i && ss_done_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_r <= SCW_PG_IDLE;
      cnt_r <= '0;
      pg_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pg_r <= pg_nxt;
    end
  end

  assign pg_o = pg_r;

  AST_PG_EXACT: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_06
    (state_r == SCW_PG_COUNT && state_nxt == SCW_PG_DONE) |-> CW'(cnt_r + 1'b1) == delay_cycles_i)
    else $error("power good deglitch ended at wrong count");
  AST_PG_ONCE: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_07
    (state_r == SCW_PG_DONE && rail_en_i) |=> state_r == SCW_PG_DONE)
    else $error("power good delay re-armed within one start-up");
  AST_PG_SRC: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_06
    $rose(pg_o) |-> $past(state_r == SCW_PG_DONE))
    else $error("power good rose without completed delay");
endmodule

// ### core/scw_pkg.sv
package scw_pkg;
  typedef logic [15:0] scw_word_t;
  typedef logic [7:0] scw_cmd_t;
  typedef logic [1:0] scw_sel2_t;
  typedef enum logic [1:0] {
    SCW_ST_LOAD = 2'b01,
    SCW_ST_RUN = 2'b10
  } scw_top_state_t;
  typedef enum logic [2:0] {
    SCW_PG_IDLE = 3'b001,
    SCW_PG_COUNT = 3'b010,
    SCW_PG_DONE = 3'b100
  } scw_pg_state_t;
endpackage

// ### core/scw_top.sv
`timescale 1ns/1ns
`include "scw_cfg.svh"
module scw_top #(
  parameter int PGD_CNT0 = `SCW_NS_TO_CYC(`SCW_PGD_T0_NS),
  parameter int PGD_CNT1 = `SCW_NS_TO_CYC(`SCW_PGD_T1_NS),
  parameter int PGD_CNT2 = `SCW_NS_TO_CYC(`SCW_PGD_T2_NS),
  parameter int PGD_CNT3 = `SCW_NS_TO_CYC(`SCW_PGD_T3_NS)
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic nvm_valid_i,
  input wire scw_pkg::scw_word_t nvm_word_i,
  output logic nvm_loaded_o,
  input wire logic txn_valid_i,
  input wire logic txn_write_i,
  input wire scw_pkg::scw_cmd_t txn_cmd_i,
  input wire scw_pkg::scw_word_t txn_wdata_i,
  input wire logic txn_pec_present_i,
  input wire logic txn_pec_ok_i,
  output logic txn_ack_o,
  output logic txn_reject_o,
  output logic rd_valid_o,
  output scw_pkg::scw_word_t rd_data_o,
  input wire logic strap_external_divider_status_i,
  input wire logic stacked_i,
  input wire logic primary_i,
  input wire logic rail_en_req_i,
  output logic rail_enable_o,
  input wire logic softstart_active_i,
  input wire logic softstart_done_i,
  input wire logic zero_cross_i,
  output logic discontinuous_mode_o,
  output logic low_side_switch_off_o,
  output logic power_good_out_o,
  output scw_pkg::scw_sel2_t undercurrent_threshold_sel_o,
  output logic fixed_overvoltage_fault_en_o,
  output logic fixed_overvoltage_level_sel_o,
  output logic high_reset_threshold_sel_o,
  output logic output_reset_enable_o
);
  import scw_pkg::*;

  localparam int CW = `SCW_PGD_CW;

  if (PGD_CNT0 < 1 || PGD_CNT1 < 1 || PGD_CNT2 < 1 || PGD_CNT3 < 1) begin : g_chk_min
    $error("power good delay counts must be at least one cycle");
  end
  if (PGD_CNT0 >= (1 << CW) || PGD_CNT1 >= (1 << CW) || PGD_CNT2 >= (1 << CW) ||
      PGD_CNT3 >= (1 << CW)) begin : g_chk_max
    $error("power good delay count exceeds counter width");
  end

  scw_top_state_t state_r, state_nxt;
  scw_word_t word_r, word_nxt;
  logic strap_r, strap_nxt;
  logic forced_continuous_sel_app_r, forced_continuous_sel_app_nxt;
  scw_sel2_t pgd_app_r, pgd_app_nxt;
  logic ack_r, ack_nxt;
  logic rej_r, rej_nxt;
  logic rdv_r, rdv_nxt;
  scw_word_t rdd_r, rdd_nxt;
  logic dcm_r, dcm_nxt;
  logic lsoff_r, lsoff_nxt;
  scw_sel2_t uth_r, uth_nxt;
  logic ovf_en_r, ovf_en_nxt;
  logic ovl_r, ovl_nxt;
  logic hirst_r, hirst_nxt;
  logic rsten_r, rsten_nxt;
  logic pec_accept;
  logic hit;
  logic [CW-1:0] delay_cycles;
  scw_word_t read_word;

  scw_pec_gate u_pec (
    .checksum_required_i(word_r[`SCW_B_PEC]),
    .primary_i(primary_i),
    .pec_present_i(txn_pec_present_i),
    .pec_ok_i(txn_pec_ok_i),
    .accept_o(pec_accept)
  );

  // Only the applied delay select matters, so a live write cannot shorten a running window
  always_comb begin
    case (pgd_app_r)
      `SCW_PGD_SEL_0: delay_cycles = CW'(PGD_CNT0); // RULE_06
      `SCW_PGD_SEL_1: delay_cycles = CW'(PGD_CNT1);
      `SCW_PGD_SEL_2: delay_cycles = CW'(PGD_CNT2);
      default: delay_cycles = CW'(PGD_CNT3);
    endcase
  end

  scw_pg_delay #(
    .CW(CW)
  ) u_pgd (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .rail_en_i(rail_enable_o),
    .ss_done_i(softstart_done_i),
    .delay_cycles_i(delay_cycles),
    .pg_o(power_good_out_o)
  );

  assign hit = txn_valid_i && (txn_cmd_i == `SCW_CMD_CODE) && (state_r == SCW_ST_RUN);

  always_comb begin
    read_word = word_r;
    read_word[`SCW_B_EXTDIV] = strap_r; // RULE_14
  end

  // Register file and load sequence
  always_comb begin
    state_nxt = state_r;
    word_nxt = word_r;
    strap_nxt = strap_r;
    ack_nxt = 1'b0;
    rej_nxt = 1'b0;
    rdv_nxt = 1'b0;
    rdd_nxt = rdd_r;
    case (state_r)
      SCW_ST_LOAD: begin
        // Strap is sampled while loading, after reset release
        strap_nxt = strap_external_divider_status_i;
        if (nvm_valid_i) begin
          word_nxt = nvm_word_i & `SCW_STORE_MASK; // RULE_16 RULE_04
          state_nxt = SCW_ST_RUN;
        end
      end
      SCW_ST_RUN: begin
        if (hit) begin
          if (!pec_accept) begin
            rej_nxt = 1'b1; // RULE_12
          end else begin
            ack_nxt = 1'b1; // RULE_13
            if (txn_write_i) begin
              // Divider status and unsupported bits are dropped on write
              word_nxt = txn_wdata_i & `SCW_STORE_MASK; // RULE_02 RULE_04 RULE_14
            end else begin
              rdv_nxt = 1'b1;
              rdd_nxt = read_word; // RULE_13
            end
          end
        end
      end
      default: state_nxt = SCW_ST_LOAD;
    endcase
    if (stacked_i && state_nxt == SCW_ST_RUN) begin
      word_nxt[`SCW_B_FORCED_CONTINUOUS_SEL] = 1'b1; // RULE_03
    end
  end

  // Settings that reach the converter only while the rail is off
  always_comb begin
    forced_continuous_sel_app_nxt = forced_continuous_sel_app_r;
    pgd_app_nxt = pgd_app_r;
    // Next word, so a load on the edge that lets the rail start is not missed
    if (!rail_enable_o) begin
      forced_continuous_sel_app_nxt = word_nxt[`SCW_B_FORCED_CONTINUOUS_SEL] || stacked_i; // RULE_02 RULE_03
      pgd_app_nxt = word_nxt[`SCW_F_PGD_HI:`SCW_F_PGD_LO]; // RULE_08
    end
  end

  // Conduction mode and analog selects
  always_comb begin
    if (stacked_i) begin
      dcm_nxt = 1'b0; // RULE_03
    end else if (softstart_active_i) begin
      dcm_nxt = word_r[`SCW_B_SSDCM]; // RULE_05
    end else begin
      dcm_nxt = !forced_continuous_sel_app_r; // RULE_01
    end
    // Low-side switch turns off at zero crossing only when discontinuous
    lsoff_nxt = dcm_r && zero_cross_i && rail_enable_o; // RULE_01
    uth_nxt = word_r[`SCW_F_UTH_HI:`SCW_F_UTH_LO]; // RULE_09
    ovf_en_nxt = !word_r[`SCW_B_OVDIS]; // RULE_15
    ovl_nxt = word_r[`SCW_B_OVLVL];
    hirst_nxt = word_r[`SCW_B_HIRST];
    rsten_nxt = word_r[`SCW_B_RSTEN];
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_r <= SCW_ST_LOAD;
      word_r <= `SCW_RESET_WORD;
      strap_r <= 1'b0;
      forced_continuous_sel_app_r <= 1'b1;
      pgd_app_r <= `SCW_PGD_SEL_0;
      ack_r <= 1'b0;
      rej_r <= 1'b0;
      rdv_r <= 1'b0;
      rdd_r <= `SCW_RESET_WORD;
      dcm_r <= 1'b0;
      lsoff_r <= 1'b0;
      uth_r <= `SCW_PGD_SEL_0;
      ovf_en_r <= 1'b1;
      ovl_r <= 1'b0;
      hirst_r <= 1'b0;
      rsten_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      word_r <= word_nxt;
      strap_r <= strap_nxt;
      forced_continuous_sel_app_r <= forced_continuous_sel_app_nxt;
      pgd_app_r <= pgd_app_nxt;
      ack_r <= ack_nxt;
      rej_r <= rej_nxt;
      rdv_r <= rdv_nxt;
      rdd_r <= rdd_nxt;
      dcm_r <= dcm_nxt;
      lsoff_r <= lsoff_nxt;
      uth_r <= uth_nxt;
      ovf_en_r <= ovf_en_nxt;
      ovl_r <= ovl_nxt;
      hirst_r <= hirst_nxt;
      rsten_r <= rsten_nxt;
    end
  end

  assign nvm_loaded_o = (state_r == SCW_ST_RUN);
  // Rail request is held off until configuration is valid
  assign rail_enable_o = rail_en_req_i && (state_r == SCW_ST_RUN); // RULE_16
  assign txn_ack_o = ack_r;
  assign txn_reject_o = rej_r;
  assign rd_valid_o = rdv_r;
  assign rd_data_o = rdd_r;
  assign discontinuous_mode_o = dcm_r;
  assign low_side_switch_off_o = lsoff_r;
  assign undercurrent_threshold_sel_o = uth_r;
  assign fixed_overvoltage_fault_en_o = ovf_en_r;
  assign fixed_overvoltage_level_sel_o = ovl_r;
  assign high_reset_threshold_sel_o = hirst_r;
  assign output_reset_enable_o = rsten_r;

  AST_STACK_FORCED_CONTINUOUS_SEL: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_03
    (stacked_i && state_r == SCW_ST_RUN) |=> word_r[`SCW_B_FORCED_CONTINUOUS_SEL])
    else $error("forced continuous not held in stacked mode");
  AST_RSVD_ZERO: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_04
    rd_valid_o |-> (rd_data_o[`SCW_F_RSVA_HI:`SCW_F_RSVA_LO] == 2'h0 &&
      rd_data_o[`SCW_F_RSVB_HI:`SCW_F_RSVB_LO] == 2'h0))
    else $error("unsupported bits read non-zero");
  AST_FORCED_CONTINUOUS_SEL_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_02
    (rail_enable_o && !stacked_i) |=> $stable(forced_continuous_sel_app_r))
    else $error("forced continuous applied while rail enabled");
  AST_PGD_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_08
    rail_enable_o |=> $stable(pgd_app_r))
    else $error("power good delay applied while rail enabled");
  AST_WR_STORE: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_02
    (hit && pec_accept && txn_write_i && !stacked_i) |=>
      (word_r[`SCW_B_FORCED_CONTINUOUS_SEL] == $past(txn_wdata_i[`SCW_B_FORCED_CONTINUOUS_SEL]) && txn_ack_o))
    else $error("accepted write not stored");
  AST_SS_DCM: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_05
    (softstart_active_i && !stacked_i) |=> discontinuous_mode_o == $past(word_r[`SCW_B_SSDCM]))
    else $error("soft start discontinuous setting not honoured");
  AST_PEC_REJ: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_12
    (hit && !txn_pec_present_i && primary_i && word_r[`SCW_B_PEC]) |=>
      (txn_reject_o && !txn_ack_o && !rd_valid_o))
    else $error("missing checksum not rejected");
  AST_PEC_IGN: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_10
    (hit && !txn_pec_present_i && !primary_i) |=> (txn_ack_o && !txn_reject_o))
    else $error("checksum requirement applied on non-primary");
  AST_EXTDIV: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_14
    rd_valid_o |-> rd_data_o[`SCW_B_EXTDIV] == strap_r)
    else $error("divider status not the strapped value");
  AST_OVF: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_15
    ##1 fixed_overvoltage_fault_en_o == !$past(word_r[`SCW_B_OVDIS]))
    else $error("fixed overvoltage enable polarity wrong");
  AST_LOAD_FIRST: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_16
    (state_r == SCW_ST_LOAD) |-> (!rail_enable_o && !txn_ack_o && !rd_valid_o))
    else $error("served before nonvolatile load");
  AST_LS_OFF: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_01
    ##1 low_side_switch_off_o == $past(discontinuous_mode_o && zero_cross_i && rail_enable_o))
    else $error("low side switch off outside discontinuous zero crossing");
endmodule

// ### tb/scw_host_model.sv
`timescale 1ns/1ns
module scw_host_model (
  input wire logic core_clk_i,
  input wire logic ack_i,
  input wire logic rej_i,
  input wire logic rdv_i,
  input wire scw_pkg::scw_word_t rdata_i,
  output logic valid_o,
  output logic write_o,
  output scw_pkg::scw_cmd_t cmd_o,
  output scw_pkg::scw_word_t wdata_o,
  output logic pec_present_o,
  output logic pec_ok_o
);
  import scw_pkg::*;
  logic [2:0] seen;
  scw_word_t rword;
  initial begin
    valid_o = 1'b0;
    write_o = 1'b0;
    cmd_o = 8'h00;
    wdata_o = 16'h0000;
    pec_present_o = 1'b0;
    pec_ok_o = 1'b0;
    seen = 3'h0;
    rword = 16'h0000;
  end
  // One decoded Write Word or Read Word; the answer is gathered as {ack, reject, read valid}
  task automatic xfer(input logic wr, input scw_cmd_t cmd, input scw_word_t d,
                      input logic pp, input logic pok);
    seen = 3'h0;
    rword = 16'h0000;
    @(negedge core_clk_i);
    valid_o = 1'b1;
    write_o = wr;
    cmd_o = cmd;
    wdata_o = d;
    pec_present_o = pp;
    pec_ok_o = pok;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    // Released qualifiers show the inverse so a stale value cannot pass for a live one
    valid_o = 1'b0;
    write_o = ~wr;
    cmd_o = ~cmd;
    wdata_o = ~d;
    pec_present_o = ~pp;
    pec_ok_o = ~pok;
    for (int i = 0; i < 2; i++) begin
      seen = seen | {ack_i, rej_i, rdv_i};
      if (rdv_i === 1'b1) begin
        rword = rdata_i;
      end
      if (i == 0) begin
        @(negedge core_clk_i);
      end
    end
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import scw_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic nvm_valid_i = 1'b0;
  scw_word_t nvm_word_i = 16'h0000;
  logic txn_valid_i, txn_write_i, txn_pec_present_i, txn_pec_ok_i;
  scw_cmd_t txn_cmd_i;
  scw_word_t txn_wdata_i, rd_data_o;
  logic strap_external_divider_status_i = 1'b0;
  logic stacked_i = 1'b0;
  logic primary_i = 1'b0;
  logic rail_en_req_i = 1'b1;
  logic softstart_active_i = 1'b0;
  logic softstart_done_i = 1'b0;
  logic zero_cross_i = 1'b0;
  logic nvm_loaded_o, txn_ack_o, txn_reject_o, rd_valid_o, rail_enable_o;
  logic discontinuous_mode_o, low_side_switch_off_o, power_good_out_o;
  logic fixed_overvoltage_fault_en_o, fixed_overvoltage_level_sel_o;
  logic high_reset_threshold_sel_o, output_reset_enable_o;
  scw_sel2_t undercurrent_threshold_sel_o;
  int n_fail = 0;
  int total_checks = 0;
  int lens[4] = '{2, 4, 6, 8};
  int cnt;

  scw_top #(.PGD_CNT0(2), .PGD_CNT1(4), .PGD_CNT2(6), .PGD_CNT3(8)) DUT (.core_clk_i,
    .reset_i, .nvm_valid_i, .nvm_word_i, .nvm_loaded_o, .txn_valid_i, .txn_write_i,
    .txn_cmd_i, .txn_wdata_i, .txn_pec_present_i, .txn_pec_ok_i, .txn_ack_o,
    .txn_reject_o, .rd_valid_o, .rd_data_o, .strap_external_divider_status_i, .stacked_i, .primary_i,
    .rail_en_req_i, .rail_enable_o, .softstart_active_i, .softstart_done_i,
    .zero_cross_i, .discontinuous_mode_o, .low_side_switch_off_o, .power_good_out_o,
    .undercurrent_threshold_sel_o, .fixed_overvoltage_fault_en_o,
    .fixed_overvoltage_level_sel_o, .high_reset_threshold_sel_o, .output_reset_enable_o);

  scw_host_model host (.core_clk_i(core_clk_i), .ack_i(txn_ack_o), .rej_i(txn_reject_o),
    .rdv_i(rd_valid_o), .rdata_i(rd_data_o), .valid_o(txn_valid_i),
    .write_o(txn_write_i), .cmd_o(txn_cmd_i), .wdata_o(txn_wdata_i),
    .pec_present_o(txn_pec_present_i), .pec_ok_o(txn_pec_ok_i));

  always #5 core_clk_i = ~core_clk_i;

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic wr(input scw_word_t d, input logic pp, input logic pok, input logic [2:0] e);
    host.xfer(1'b1, 8'hd1, d, pp, pok);
    chk("write answer", host.seen, e);
  endtask

  task automatic rd(input scw_word_t e, input logic pp, input logic pok, input logic [2:0] a);
    host.xfer(1'b0, 8'hd1, 16'h0000, pp, pok);
    chk("read answer", host.seen, a);
    chk("read data", host.rword, e);
  endtask

  task automatic t_reset();
    tk(1);
    chk("loaded", nvm_loaded_o, 1'b0);
    chk("rail", rail_enable_o, 1'b0);
    chk("ovf en", fixed_overvoltage_fault_en_o, 1'b1);
    rd(16'h0000, 1'b0, 1'b0, 3'h0);
  endtask

  task automatic t_load();
    nvm_word_i = 16'hffff;
    nvm_valid_i = 1'b1;
    tk(1);
    nvm_valid_i = 1'b0;
    tk(2);
    chk("loaded", nvm_loaded_o, 1'b1);
    chk("rail", rail_enable_o, 1'b1);
    chk("uc thresh", undercurrent_threshold_sel_o, 2'h3);
    chk("ovf en", fixed_overvoltage_fault_en_o, 1'b0);
    chk("lvl", {fixed_overvoltage_level_sel_o, high_reset_threshold_sel_o,
      output_reset_enable_o}, 3'h7);
    chk("dcm", discontinuous_mode_o, 1'b0);
    // A second load attempt must be ignored
    nvm_word_i = 16'h0000;
    nvm_valid_i = 1'b1;
    tk(1);
    nvm_valid_i = 1'b0;
    rail_en_req_i = 1'b0;
    rd(16'h9f8f, 1'b0, 1'b0, 3'h5);
  endtask

  task automatic t_regs();
    wr(16'h0106, 1'b0, 1'b0, 3'h4);
    tk(2);
    chk("uc thresh", undercurrent_threshold_sel_o, 2'h1);
    chk("ovf en", fixed_overvoltage_fault_en_o, 1'b1);
    chk("ovf lvl", fixed_overvoltage_level_sel_o, 1'b1);
    chk("rst sel", {high_reset_threshold_sel_o, output_reset_enable_o}, 2'h1);
    // Sets the checksum-required flag for the next scenario
    wr(16'h7fff, 1'b0, 1'b0, 3'h4);
    rd(16'h1f8f, 1'b0, 1'b0, 3'h5);
    host.xfer(1'b1, 8'hd0, 16'h0000, 1'b0, 1'b0);
    chk("other cmd", host.seen, 3'h0);
    rd(16'h1f8f, 1'b0, 1'b0, 3'h5);
  endtask

  task automatic t_pec();
    rd(16'h1f8f, 1'b0, 1'b0, 3'h5);
    primary_i = 1'b1;
    rd(16'h0000, 1'b0, 1'b0, 3'h2);
    wr(16'h0000, 1'b0, 1'b0, 3'h2);
    rd(16'h1f8f, 1'b1, 1'b1, 3'h5);
    rd(16'h0000, 1'b1, 1'b0, 3'h2);
    wr(16'h0000, 1'b1, 1'b1, 3'h4);
    rd(16'h0000, 1'b0, 1'b0, 3'h5);
    rd(16'h0000, 1'b1, 1'b0, 3'h2);
  endtask

  task automatic t_mode();
    tk(3);
    chk("dcm", discontinuous_mode_o, 1'b1);
    rail_en_req_i = 1'b1;
    zero_cross_i = 1'b1;
    tk(3);
    chk("ls off", low_side_switch_off_o, 1'b1);
    wr(16'h8000, 1'b0, 1'b0, 3'h4);
    rd(16'h8000, 1'b0, 1'b0, 3'h5);
    tk(3);
    chk("dcm", discontinuous_mode_o, 1'b1);
    rail_en_req_i = 1'b0;
    tk(3);
    chk("dcm", discontinuous_mode_o, 1'b0);
    softstart_active_i = 1'b1;
    wr(16'h9000, 1'b0, 1'b0, 3'h4);
    tk(2);
    chk("ss dcm", discontinuous_mode_o, 1'b1);
    wr(16'h8000, 1'b0, 1'b0, 3'h4);
    tk(2);
    chk("ss dcm", discontinuous_mode_o, 1'b0);
    softstart_active_i = 1'b0;
    stacked_i = 1'b1;
    wr(16'h0000, 1'b0, 1'b0, 3'h4);
    rd(16'h8000, 1'b0, 1'b0, 3'h5);
    tk(2);
    chk("stack dcm", discontinuous_mode_o, 1'b0);
    stacked_i = 1'b0;
    zero_cross_i = 1'b0;
  endtask

  task automatic t_power_good_out();
    for (int i = 0; i < 4; i++) begin
      // Written while the rail still runs on every pass after the first: held back until the next start-up
      wr({4'h0, 2'(i), 10'h000}, 1'b0, 1'b0, 3'h4);
      rd({4'h0, 2'(i), 10'h000}, 1'b0, 1'b0, 3'h5);
      rail_en_req_i = 1'b0;
      softstart_done_i = 1'b0;
      tk(2);
      rail_en_req_i = 1'b1;
      softstart_done_i = 1'b1;
      cnt = 0;
      while (power_good_out_o !== 1'b1 && cnt < 300) begin
        @(posedge core_clk_i);
        #1;
        cnt++;
      end
      chk("pg delay", 16'(cnt), 16'(lens[i] + 2));
      tk(1);
      softstart_done_i = 1'b0;
      tk(2);
      chk("pg drop", power_good_out_o, 1'b0);
      softstart_done_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      chk("pg again", power_good_out_o, 1'b1);
    end
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge core_clk_i);
    reset_i = 1'b0;
    t_reset();
    t_load();
    t_regs();
    t_pec();
    t_mode();
    t_power_good_out();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    close_out();
  end
endmodule
